/* inc/fesr_pkg.sv */
// Constants, command codes and result codes for the flash error status host.
// Assumes a 20 MHz clock and a flash whose status register answers on the same clock.
package fesr_pkg;

  // ----------------------------------------------------------------
  // Clock and documented times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned ERASE_MAX_MS = 1100;
  localparam int unsigned PROG_MAX_US = 400;
  localparam int unsigned SUSP_LAT_MAX_US = 40;
  localparam int unsigned RESUME_GAP_MIN_NS = 60;
  localparam int unsigned PROG_OPS_MAX = 256;

  // Longest times round down, least times round up.
  localparam int unsigned ERASE_CYC = ERASE_MAX_MS * (1000000 / CLK_NS);
  localparam int unsigned PROG_CYC = (PROG_MAX_US * 1000) / CLK_NS;
  localparam int unsigned SUSP_CYC = (SUSP_LAT_MAX_US * 1000) / CLK_NS;
  localparam int unsigned GAP_CYC = (RESUME_GAP_MIN_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Host timing and widths
  // ----------------------------------------------------------------
  localparam int unsigned TMR_W = 25;
  localparam int unsigned GAP_W = 2;
  localparam int unsigned POLL_W = 4;
  localparam int unsigned POLL_CYC = 16;
  localparam int unsigned RB_SETTLE_CYC = 4;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 9;

  // ----------------------------------------------------------------
  // Program count table layout
  // ----------------------------------------------------------------
  localparam int unsigned LINE_LSB = 4;
  localparam int unsigned LINE_BITS = 3;
  localparam int unsigned SEC_LSB = 14;
  localparam int unsigned SEC_BITS = 2;
  localparam int unsigned IDX_W = LINE_BITS + SEC_BITS;
  localparam int unsigned N_ENTRY = 32;

  // ----------------------------------------------------------------
  // Operation status register fields
  // ----------------------------------------------------------------
  localparam int unsigned OS_VALID = 7;
  localparam int unsigned OS_ERASE_ERR = 5;
  localparam int unsigned OS_PROG_ERR = 4;
  localparam int unsigned OS_ABORT = 3;
  localparam int unsigned OS_PROT = 1;
  localparam logic [7:0] OS_MASK = 8'hbe;
  localparam logic [7:0] OS_CLEAN = 8'h80;
  localparam logic [7:0] OS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE, CMD_PROGRAM, CMD_ERASE, CMD_SUSPEND, CMD_RESUME,
    CMD_STAT_READ, CMD_STAT_CLEAR, CMD_ABORT_RESET, CMD_RESET
  } fesr_cmd_t;

  typedef enum logic [1:0] {OP_NONE, OP_PROGRAM, OP_ERASE, OP_RESUME} fesr_op_t;

  typedef enum logic [2:0] {
    RES_OK, RES_PROTECT, RES_ABORT, RES_FAIL, RES_TIMEOUT, RES_REFUSED, RES_SUSPENDED
  } fesr_res_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOKUP, ST_BUSY, ST_POLL, ST_FINAL, ST_SUSP
  } fesr_state_t;

endpackage

/* hw/fesr_line_mem.sv */
// Table of program counts per tracked line, with registered read data.
// Assumes one read and one write per cycle; a write beats a sector clear.
module fesr_line_mem
  import fesr_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Read port
  input logic rd_en,
  input logic [IDX_W-1:0] rd_idx,
  output logic [CNT_W-1:0] rd_cnt,
  // Write port
  input logic wr_en,
  input logic [IDX_W-1:0] wr_idx,
  input logic [CNT_W-1:0] wr_cnt,
  // Sector clear
  input logic clr_en,
  input logic [SEC_BITS-1:0] clr_sector
);

  typedef struct packed {
    logic [N_ENTRY-1:0][CNT_W-1:0] cnt;
    logic [N_ENTRY-1:0] vld;
    logic [CNT_W-1:0] rd;
  } fesr_mem_t;

  fesr_mem_t q;
  fesr_mem_t d;
  wire [N_ENTRY-1:0][CNT_W-1:0] cnt_n;
  wire [N_ENTRY-1:0] vld_n;

  // ----------------------------------------------------------------
  // Per entry update
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_ENTRY; i++)
  begin : g_ent
    localparam logic [IDX_W-1:0] IDX = IDX_W'(i);
    wire hit = wr_en && (wr_idx == IDX);
    wire clr = clr_en && (IDX[IDX_W-1 -: SEC_BITS] == clr_sector);
    assign vld_n[i] = hit | (q.vld[i] & ~clr);
    assign cnt_n[i] = hit ? wr_cnt : q.cnt[i];
  end

  always_comb
  begin
    d = q;
    d.cnt = cnt_n;
    d.vld = vld_n;
    if (rd_en)
    begin
      d.rd = q.vld[rd_idx] ? q.cnt[rd_idx] : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_cnt = q.rd;

endmodule

/* hw/fesr_host.sv */
// Host controller that issues program, erase, suspend and resume to a flash,
// watches ready_busy_n and the operation status register, and clears errors.
// Assumes the flash answers a status read with fl_rdata_valid on this clock.
//
// What this block does
// - While busy only status reads, suspend, status clear, abort reset and timeout reset are sent
// - Erase timer bit masked unless erase suspended; the host's masking ignores suspension, OS_MASK is fixed
// - Erase toggle bit masked unless erase suspended; the host's masking ignores suspension, OS_MASK is fixed
// - Buffer abort cleared by abort-reset command
// - Reserved status bits 0 and 6 masked in the final status read; poll reads pass them to status unmasked
// - At least 60 ns from resume to suspend
// - At most 256 programs per line per erase
module fesr_host
  import fesr_pkg::*;
#(
  parameter int unsigned ERASE_CYC_P = ERASE_CYC,
  parameter int unsigned PROG_CYC_P = PROG_CYC
)
(
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // User requests
  input logic req_valid,
  input fesr_op_t req_op,
  input logic [ADDR_W-1:0] req_addr,
  input logic [DATA_W-1:0] req_data,
  output logic req_ready,
  input logic suspend_req,
  // User results
  output logic done,
  output fesr_res_t result,
  output logic [7:0] status,
  output logic suspended,
  // Flash side
  output logic fl_cmd_valid,
  output fesr_cmd_t fl_cmd,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] fl_wdata,
  input logic fl_rdata_valid,
  input logic [7:0] fl_rdata,
  input logic ready_busy_n
);

  typedef struct packed {
    fesr_state_t state;
    fesr_op_t op;
    fesr_op_t sop;
    logic cmd_v;
    fesr_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] limit;
    logic [POLL_W-1:0] poll;
    logic [GAP_W-1:0] gap;
    logic rb_m;
    logic rb_s;
    logic ready;
    logic done;
    fesr_res_t res;
    logic [7:0] status;
    logic susp;
  } fesr_host_t;

  fesr_host_t q;
  fesr_host_t d;
  logic mem_rd;
  logic mem_wr;
  logic mem_clr;
  logic busy_like;
  logic [CNT_W-1:0] mem_cnt;

  // ----------------------------------------------------------------
  // Program count table
  // ----------------------------------------------------------------
  fesr_line_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .rd_en(mem_rd),
    .rd_idx({req_addr[SEC_LSB +: SEC_BITS], req_addr[LINE_LSB +: LINE_BITS]}),
    .rd_cnt(mem_cnt),
    .wr_en(mem_wr),
    .wr_idx({q.addr[SEC_LSB +: SEC_BITS], q.addr[LINE_LSB +: LINE_BITS]}),
    .wr_cnt(mem_cnt + CNT_W'(1)),
    .clr_en(mem_clr),
    .clr_sector(q.addr[SEC_LSB +: SEC_BITS])
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.cmd_v = 1'b0;
    d.cmd = CMD_NONE;
    d.done = 1'b0;
    d.rb_m = ready_busy_n;
    d.rb_s = q.rb_m;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_clr = 1'b0;
    busy_like = q.state inside {ST_BUSY, ST_POLL, ST_FINAL, ST_SUSP};
    if (q.gap != '0)
    begin
      d.gap = q.gap - GAP_W'(1);
    end
    if (busy_like)
    begin
      d.tmr = q.tmr + TMR_W'(1);
    end
    // A stuck operation is abandoned and the flash is put back to read mode.
    if (busy_like && q.tmr >= q.limit)
    begin
      d.cmd_v = 1'b1;
      d.cmd = CMD_RESET;
      d.done = 1'b1;
      d.res = RES_TIMEOUT;
      d.state = ST_IDLE;
    end
    else
    begin
      case (q.state)
        ST_IDLE:
        begin
          if (q.ready && req_valid)
          begin
            d.done = 1'b1;
            d.res = RES_REFUSED;
            d.tmr = '0;
            d.poll = '0;
            if (req_op == OP_PROGRAM)
            begin
              d.done = 1'b0;
              d.op = OP_PROGRAM;
              d.addr = req_addr;
              d.wdata = req_data;
              mem_rd = 1'b1;
              d.state = ST_LOOKUP;
            end
            else if (req_op == OP_ERASE && !q.susp)
            begin
              d.done = 1'b0;
              d.op = OP_ERASE;
              d.addr = req_addr;
              d.cmd_v = 1'b1;
              d.cmd = CMD_ERASE;
              d.limit = TMR_W'(ERASE_CYC_P);
              d.state = ST_BUSY;
            end
            else if (req_op == OP_RESUME && q.susp)
            begin
              d.done = 1'b0;
              d.op = q.sop;
              d.susp = 1'b0;
              d.cmd_v = 1'b1;
              d.cmd = CMD_RESUME;
              d.gap = GAP_W'(GAP_CYC);
              d.limit = (q.sop == OP_ERASE) ? TMR_W'(ERASE_CYC_P) : TMR_W'(PROG_CYC_P);
              d.state = ST_BUSY;
            end
          end
        end
        ST_LOOKUP:
        begin
          if (mem_cnt >= CNT_W'(PROG_OPS_MAX))
          begin
            d.done = 1'b1;
            d.res = RES_REFUSED;
            d.state = ST_IDLE;
          end
          else
          begin
            mem_wr = 1'b1;
            d.cmd_v = 1'b1;
            d.cmd = CMD_PROGRAM;
            d.limit = TMR_W'(PROG_CYC_P);
            d.state = ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          d.poll = q.poll + POLL_W'(1);
          if (suspend_req && q.gap == '0 && !q.susp)
          begin
            d.cmd_v = 1'b1;
            d.cmd = CMD_SUSPEND;
            d.sop = q.op;
            d.tmr = '0;
            d.limit = TMR_W'(SUSP_CYC);
            d.state = ST_SUSP;
          end
          else if (q.rb_s && q.tmr >= TMR_W'(RB_SETTLE_CYC))
          begin
            d.cmd_v = 1'b1;
            d.cmd = CMD_STAT_READ;
            d.state = ST_FINAL;
          end
          else if (q.poll == POLL_W'(POLL_CYC - 1))
          begin
            // Polling bits are not used: their overlay varies by error type and address.
            d.cmd_v = 1'b1;
            d.cmd = CMD_STAT_READ;
            d.state = ST_POLL;
          end
        end
        ST_POLL:
        begin
          if (fl_rdata_valid)
          begin
            d.status = fl_rdata;
            d.poll = '0;
            d.state = ST_BUSY;
            if (fl_rdata[OS_VALID])
            begin
              // Valid status while still busy means the device waits for a clear.
              d.done = 1'b1;
              d.cmd_v = 1'b1;
              d.state = ST_IDLE;
              if (fl_rdata[OS_ABORT])
              begin
                d.cmd = CMD_ABORT_RESET;
                d.res = RES_ABORT;
              end
              else
              begin
                d.cmd = CMD_STAT_CLEAR;
                d.res = RES_FAIL;
              end
            end
          end
        end
        ST_FINAL:
        begin
          if (fl_rdata_valid)
          begin
            d.status = fl_rdata & OS_MASK;
            d.poll = '0;
            d.state = ST_BUSY;
            if (fl_rdata[OS_VALID])
            begin
              // The suspend flag is left alone so the erase can still be resumed.
              d.done = 1'b1;
              d.state = ST_IDLE;
              d.res = RES_OK;
              if (fl_rdata[OS_PROT])
              begin
                d.cmd_v = 1'b1;
                d.cmd = CMD_STAT_CLEAR;
                d.res = RES_PROTECT;
              end
              else if (fl_rdata[OS_ERASE_ERR] || fl_rdata[OS_PROG_ERR])
              begin
                d.cmd_v = 1'b1;
                d.cmd = CMD_STAT_CLEAR;
                d.res = RES_FAIL;
              end
              else if (q.op == OP_ERASE)
              begin
                mem_clr = 1'b1;
              end
            end
          end
        end
        ST_SUSP:
        begin
          if (q.rb_s && q.tmr >= TMR_W'(RB_SETTLE_CYC))
          begin
            d.susp = 1'b1;
            d.done = 1'b1;
            d.res = RES_SUSPENDED;
            d.state = ST_IDLE;
          end
        end
        default:
        begin
          d.state = ST_IDLE;
        end
      endcase
    end
    d.ready = (d.state == ST_IDLE) && !(q.ready && req_valid);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign req_ready = q.ready;
  assign done = q.done;
  assign result = q.res;
  assign status = q.status;
  assign suspended = q.susp;
  assign fl_cmd_valid = q.cmd_v;
  assign fl_cmd = q.cmd;
  assign fl_addr = q.addr;
  assign fl_wdata = q.wdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_abort_seen;
    q.state == ST_POLL && fl_rdata_valid && fl_rdata[OS_VALID] && fl_rdata[OS_ABORT];
  endsequence

  sequence s_resume_sent;
    q.cmd_v && q.cmd == CMD_RESUME;
  endsequence

  sequence s_final_read;
    q.state == ST_FINAL && fl_rdata_valid && fl_rdata[OS_VALID];
  endsequence

  a_busy_cmd_only: assert property (
    (q.cmd_v && $past(q.state) == ST_BUSY) |-> q.cmd inside {CMD_STAT_READ, CMD_SUSPEND, CMD_RESET})
    else $error("Command other than status read sent while busy.");

  a_abort_reset_sent: assert property (
    s_abort_seen |=> q.cmd_v && q.cmd == CMD_ABORT_RESET && q.done && q.res == RES_ABORT)
    else $error("Buffer abort not cleared by abort reset.");

  a_protect_reported: assert property (
    (s_final_read and fl_rdata[OS_PROT]) |=> q.done && q.res == RES_PROTECT ##1 !q.done)
    else $error("Protection error not reported.");

  a_reserved_masked: assert property (
    (s_final_read and ((fl_rdata & OS_MASK) == OS_CLEAN)) |=> q.done && q.res == RES_OK)
    else $error("Reserved status bits changed the result.");

  a_resume_gap_kept: assert property (
    s_resume_sent |=> (!(q.cmd_v && q.cmd == CMD_SUSPEND))[*2])
    else $error("Suspend sent too soon after resume.");

  a_nop_limit_kept: assert property (
    (q.cmd_v && q.cmd == CMD_PROGRAM) |-> $past(mem_cnt) < CNT_W'(PROG_OPS_MAX))
    else $error("Line programmed beyond its limit.");

  a_timeout_resets: assert property (
    (busy_like && q.tmr >= q.limit) |=> q.cmd_v && q.cmd == CMD_RESET && q.done
      && q.res == RES_TIMEOUT && q.state == ST_IDLE)
    else $error("Overlong operation not reset.");

  a_suspend_bounded: assert property (
    (q.cmd_v && q.cmd == CMD_SUSPEND) |-> ##[1:801] (q.state == ST_IDLE && q.done))
    else $error("Suspend not concluded within its latency.");

endmodule

/* tb/fesr_flash_model.sv */
// Behavioural flash reached through its command pulse and status register port.
// Assumes one-cycle command pulses on the host clock; the bench picks the outcome.
module fesr_flash_model
  import fesr_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Outcome: 0 pass, 1 protected, 2 buffer abort, 3 never finishes
  input logic [1:0] mode,
  input logic [11:0] busy_cyc,
  input logic [3:0] ans_dly,
  // Host side
  input logic fl_cmd_valid,
  input fesr_cmd_t fl_cmd,
  input logic [DATA_W-1:0] fl_wdata,
  output logic fl_rdata_valid,
  output logic [7:0] fl_rdata,
  output logic ready_busy_n,
  output logic viol
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Embedded algorithm
  // ------------------------------------------------------------
  logic busy;
  logic erase;
  logic [7:0] stat;
  logic [7:0] ans;
  int cnt;
  int rd;

  always @(posedge clk)
  begin
    viol <= 1'b0;
    fl_rdata_valid <= 1'b0;
    // An idle status bus keeps changing, so a stale byte never passes for an answer.
    // While busy, every read outside an answer shows the polling overlay instead.
    if (busy)
      fl_rdata <= {~erase & ~fl_wdata[7], ~fl_rdata[6], 1'b0, 1'b0, 1'b1, ~fl_rdata[2],
          mode == 2'd2, 1'b0};
    else
      fl_rdata <= ~fl_rdata;
    if (!rst_n)
    begin
      busy = 1'b0;
      stat = 8'h80;
      rd = 0;
      ready_busy_n <= 1'b1;
      fl_rdata <= 8'h5a;
    end
    else
    begin
      if (rd > 0)
      begin
        rd = rd - 1;
        if (rd == 0)
        begin
          fl_rdata_valid <= 1'b1;
          fl_rdata <= ans;
        end
      end
      // Abort and hang wait to be cleared; the others end by themselves.
      if (busy && mode < 2'd2)
      begin
        cnt = cnt - 1;
        if (cnt <= 0)
        begin
          busy = 1'b0;
          ready_busy_n <= 1'b1;
          // Bits 6 and 0 are set so that the host has to mask them.
          stat = (mode == 2'd0) ? 8'hc1 : (erase ? 8'he3 : 8'hd3);
        end
      end
      if (fl_cmd_valid)
      begin
        if (busy && ((mode == 2'd1 && fl_cmd != CMD_STAT_READ) || (mode == 2'd2 &&
            !(fl_cmd inside {CMD_STAT_READ, CMD_STAT_CLEAR, CMD_ABORT_RESET}))))
          viol <= 1'b1;
        case (fl_cmd)
          CMD_PROGRAM, CMD_ERASE, CMD_RESUME:
          begin
            busy = 1'b1;
            ready_busy_n <= 1'b0;
            cnt = busy_cyc;
            if (fl_cmd != CMD_RESUME)
              erase = (fl_cmd == CMD_ERASE);
            stat = (mode == 2'd2) ? 8'hd9 : 8'h35;
          end
          CMD_SUSPEND:
            cnt = 12;
          CMD_STAT_READ:
          begin
            rd = ans_dly;
            ans = stat;
          end
          default:
          begin
            busy = 1'b0;
            ready_busy_n <= 1'b1;
            stat = 8'h80;
          end
        endcase
      end
    end
  end
endmodule

/* tb/fesr_host_tb.sv */
// Self-checking bench: the flash error status host driving a behavioural flash.
// Assumes a 20 MHz clock; the erase timeout is shortened through its parameter.
module fesr_host_tb
  import fesr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int ERASE_T = 3000;
  logic clk = 1'b0;
  logic rst_n, req_valid, req_ready, suspend_req, done, suspended;
  logic fl_cmd_valid, fl_rdata_valid, ready_busy_n, viol;
  fesr_op_t req_op;
  fesr_res_t result;
  fesr_cmd_t fl_cmd;
  fesr_cmd_t last_cmd;
  logic [15:0] req_addr, req_data, fl_addr, fl_wdata;
  logic [7:0] status, fl_rdata;
  logic [1:0] mode;
  logic [11:0] busy_cyc;
  logic [3:0] ans_dly;
  integer seed = 32'hcab8_c898;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int gap = 100;
  int n_viol = 0;
  int lat, i;

  always #25 clk = ~clk;

  fesr_host #(.ERASE_CYC_P(ERASE_T), .PROG_CYC_P(PROG_CYC)) i_fesr_host (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .suspend_req(suspend_req), .done(done), .result(result), .status(status),
    .suspended(suspended), .fl_cmd_valid(fl_cmd_valid), .fl_cmd(fl_cmd),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata_valid(fl_rdata_valid),
    .fl_rdata(fl_rdata), .ready_busy_n(ready_busy_n));

  fesr_flash_model i_fesr_flash_model (
    .clk(clk), .rst_n(rst_n), .mode(mode), .busy_cyc(busy_cyc), .ans_dly(ans_dly),
    .fl_cmd_valid(fl_cmd_valid), .fl_cmd(fl_cmd), .fl_wdata(fl_wdata),
    .fl_rdata_valid(fl_rdata_valid),
    .fl_rdata(fl_rdata), .ready_busy_n(ready_busy_n), .viol(viol));

  // ------------------------------------------------------------
  // Checking and expectations
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic fesr_res_t exp_res(input logic [1:0] m);
    return (m == 2'd0) ? RES_OK : (m == 2'd1) ? RES_PROTECT : (m == 2'd2) ? RES_ABORT
      : RES_TIMEOUT;
  endfunction

  function automatic fesr_cmd_t exp_cmd(input logic [1:0] m);
    return (m == 2'd0) ? CMD_STAT_READ : (m == 2'd1) ? CMD_STAT_CLEAR
      : (m == 2'd2) ? CMD_ABORT_RESET : CMD_RESET;
  endfunction

  // Reserved bits 6 and 0 read as zero once masked.
  function automatic logic [7:0] exp_status(input logic [1:0] m, input logic er);
    return (m == 2'd1) ? (er ? 8'ha2 : 8'h92) : 8'h80;
  endfunction

  // ------------------------------------------------------------
  // Monitor and hang guard
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    gap <= gap + 1;
    if (viol === 1'b1)
      n_viol <= n_viol + 1;
    if (fl_cmd_valid === 1'b1)
    begin
      last_cmd <= fl_cmd;
      if (fl_cmd === CMD_RESUME)
        gap <= 0;
      if (fl_cmd === CMD_SUSPEND)
        chk(gap + 1 >= GAP_CYC, 1'b1, "resume to suspend gap");
    end
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      $display("ERROR run length expected below 40000 cycles seen more");
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------
  task automatic do_req(input fesr_op_t op, input logic [15:0] ad, input logic [15:0] dt,
      input logic [1:0] m, input int bc, input logic sp, input fesr_res_t er);
    @(posedge clk);
    while (req_ready !== 1'b1)
      @(posedge clk);
    mode <= m;
    busy_cyc <= 12'(bc);
    ans_dly <= 4'(1 + {$random(seed)} % 8);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= ad;
    req_data <= dt;
    suspend_req <= sp;
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 9000)
    begin
      @(posedge clk);
      lat = lat + 1;
    end
    suspend_req <= 1'b0;
    chk(result, er, "result");
  endtask

  task automatic op_chk(input fesr_op_t op, input logic [15:0] ad, input logic [1:0] m,
      input int bc);
    logic [15:0] dt;
    dt = 16'($random(seed));
    do_req(op, ad, dt, m, bc, 1'b0, exp_res(m));
    chk(fl_addr, ad, "address");
    // Only a program loads write data; an erase leaves the last word in place.
    if (op == OP_PROGRAM)
      chk(fl_wdata, dt, "write data");
    if (m < 2'd2)
      chk(status, exp_status(m, op == OP_ERASE), "status");
    if (m == 2'd1)
      chk(lat >= bc, 1'b1, "protection busy time");
    repeat (2) @(posedge clk);
    chk(last_cmd, exp_cmd(m), "last command");
  endtask

  task automatic end_test(input string name);
    $display("test %s finished with %0d failures so far", name, n_fail);
  endtask

  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = OP_NONE;
    req_addr = 16'h0000;
    req_data = 16'h0000;
    suspend_req = 1'b0;
    mode = 2'h0;
    busy_cyc = 12'h005;
    ans_dly = 4'h1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
      op_chk(OP_PROGRAM, 16'($random(seed)), 2'd0, 5 + i);
    end_test("program");
    op_chk(OP_PROGRAM, 16'h4123, 2'd1, 408);
    op_chk(OP_ERASE, 16'hc000, 2'd1, 2000);
    op_chk(OP_PROGRAM, 16'h4124, 2'd0, 5);
    end_test("protection");
    op_chk(OP_PROGRAM, 16'h8010, 2'd2, 5);
    op_chk(OP_PROGRAM, 16'h8011, 2'd0, 5);
    end_test("buffer abort");
    op_chk(OP_ERASE, 16'h4000, 2'd3, 5);
    end_test("timeout");
    do_req(OP_ERASE, 16'h0000, 16'h0000, 2'd0, 1000, 1'b1, RES_SUSPENDED);
    chk(suspended, 1'b1, "suspended flag");
    do_req(OP_ERASE, 16'h0000, 16'h0000, 2'd0, 1000, 1'b0, RES_REFUSED);
    do_req(OP_RESUME, 16'h0000, 16'h0000, 2'd0, 1000, 1'b1, RES_SUSPENDED);
    do_req(OP_RESUME, 16'h0000, 16'h0000, 2'd0, 104, 1'b0, RES_OK);
    chk(suspended, 1'b0, "suspended flag");
    do_req(OP_RESUME, 16'h0000, 16'h0000, 2'd0, 5, 1'b0, RES_REFUSED);
    do_req(OP_NONE, 16'h0000, 16'h0000, 2'd0, 5, 1'b0, RES_REFUSED);
    end_test("suspend");
    op_chk(OP_ERASE, 16'h0000, 2'd0, 5);
    for (i = 0; i < 257; i++)
      do_req(OP_PROGRAM, 16'h0050, 16'(i), 2'd0, 5, 1'b0, (i < 256) ? RES_OK : RES_REFUSED);
    op_chk(OP_ERASE, 16'h0000, 2'd0, 5);
    op_chk(OP_PROGRAM, 16'h0050, 2'd0, 5);
    end_test("program count");
    chk(n_viol, 0, "commands refused while busy");
    wrap_up();
  end
endmodule
